// ==== core/glp_pkg.sv ====
// Package of constants and types for the pin function configuration block.
`default_nettype none

package glp_pkg;

  localparam int NUM_PINS = 3;

  // Register byte addresses on the bus.
  localparam logic [31:0] ADDR_CFG = 32'h0000_0088;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'h0000_0080;
  localparam logic [31:0] ADDR_IRQ_ENABLE = 32'h0000_0084;
  localparam logic [7:0] ADDR_DECODE_MASK = 8'hFC;

  // Writable bits of the configuration register; everything else is reserved.
  localparam logic [31:0] CFG_WMASK = 32'h7777_071F;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  // Interrupt status and enable share this layout.
  localparam int IRQ_PIN_LSB = 0;
  localparam int IRQ_BAD_ROUTE = 3;
  localparam int IRQ_ROUTE_BUSY = 4;
  localparam logic [31:0] IRQ_WMASK = 32'h0000_001F;
  localparam logic [31:0] IRQ_RESET = 32'h0000_0000;

  // Input qualification time for pin interrupts.
  localparam int CLK_PERIOD_NS = 20;
  localparam int FILTER_NS = 40;
  localparam int FILTER_CYCLES_INT = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] FILTER_CYCLES = 2'(FILTER_CYCLES_INT < 1 ? 1 : FILTER_CYCLES_INT);

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [2:0] {
    ROUTE_ROM = 3'h0,
    ROUTE_GPO = 3'h1,
    ROUTE_RSV_A = 3'h2,
    ROUTE_GPO_RXDV = 3'h3,
    ROUTE_RSV_B = 3'h4,
    ROUTE_TXEN_GPO = 3'h5,
    ROUTE_TXEN_RXDV = 3'h6,
    ROUTE_MII_CLK = 3'h7
  } glp_route_t;

  typedef struct packed {
    logic rsv31;
    logic [2:0] indicator_select;
    logic rsv27;
    logic [2:0] pin_irq_level_select;
    logic rsv23;
    logic [2:0] serial_rom_pin_function;
    logic rsv19;
    logic [2:0] pin_push_pull_select;
    logic [4:0] rsv15_11;
    logic [2:0] pin_direction;
    logic [2:0] rsv7_5;
    logic [1:0] output_only_value;
    logic [2:0] pin_value;
  } glp_cfg_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [3:0] lanes;
  } glp_aphase_t;

  typedef struct packed {
    logic out;
    logic oe;
  } glp_drive_t;

endpackage

`default_nettype wire

// ==== core/glp_level_filter.sv ====
// Level qualifier that reports a pin level only after it has held for the filter time.
`default_nettype none

module glp_level_filter (
  input wire logic clk,
  input wire logic resetn,
  input wire logic level,
  input wire logic active_high,
  input wire logic armed,
  output logic match
);
  import glp_pkg::*;

  logic [1:0] held;

  // A glitch shorter than the filter time restarts the count, so it never qualifies.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      held <= 2'h0;
    end else if (!armed || (level != active_high)) begin
      held <= 2'h0;
    end else if (held != FILTER_CYCLES) begin
      held <= held + 2'h1;
    end
  end

  assign match = (held == FILTER_CYCLES);

endmodule

`default_nettype wire

// ==== core/glp_pin_config.sv ====
// Pin function configuration block with AHB-Lite register access and pin routing.
`default_nettype none

module glp_pin_config (
  input wire logic CLK,
  input wire logic RESETN,
  // AHB-Lite slave.
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // General pins shared with indicators.
  input wire logic [glp_pkg::NUM_PINS-1:0] GPIO_IN,
  output logic [glp_pkg::NUM_PINS-1:0] GPIO_OUT,
  output logic [glp_pkg::NUM_PINS-1:0] GPIO_OE,
  input wire logic [glp_pkg::NUM_PINS-1:0] LED_IND,
  // Serial ROM data and clock pins.
  input wire logic ROM_DATA_IN,
  output logic ROM_DATA_OUT,
  output logic ROM_DATA_OE,
  input wire logic ROM_CLK_IN,
  output logic ROM_CLK_OUT,
  output logic ROM_CLK_OE,
  // Serial ROM controller side.
  input wire logic SROM_DO,
  input wire logic SROM_DOE,
  input wire logic SROM_CLK,
  input wire logic SROM_BUSY,
  output logic SROM_DI,
  // MII signals that may borrow the ROM pins.
  input wire logic MII_TX_EN,
  output logic MII_TX_CLK,
  output logic MII_RX_DV,
  output logic MII_RX_CLK,
  // Interrupt.
  output logic IRQ
);
  import glp_pkg::*;

  // Byte lanes touched by a transfer of the given size at the given address.
  function automatic logic [3:0] lane_mask(input logic [2:0] size, input logic [1:0] low);
    logic [3:0] m;
    m = 4'h0;
    unique case (size)
      3'h0: m = 4'h1 << low;
      3'h1: m = low[1] ? 4'hC : 4'h3;
      default: m = 4'hF;
    endcase
    return m;
  endfunction

  // Expand lane enables into a bit mask.
  function automatic logic [31:0] lane_bits(input logic [3:0] lanes);
    logic [31:0] b;
    b = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      b[i*8 +: 8] = {8{lanes[i]}};
    end
    return b;
  endfunction

  // Push-pull drives both levels; open-drain only pulls low and floats for a one.
  function automatic glp_drive_t pin_drive(input logic value, input logic push_pull);
    glp_drive_t d;
    d.out = push_pull ? value : 1'b0;
    d.oe = push_pull ? 1'b1 : ~value;
    return d;
  endfunction

  // Reserved settings leave both ROM pins floating rather than guessing a route.
  function automatic logic route_legal(input logic [2:0] code);
    return (code != ROUTE_RSV_A) && (code != ROUTE_RSV_B);
  endfunction

  glp_aphase_t aphase;
  glp_aphase_t next_aphase;
  glp_cfg_t cfg;
  glp_cfg_t next_cfg;
  logic [31:0] irq_status;
  logic [31:0] next_irq_status;
  logic [31:0] irq_enable;
  logic [31:0] next_irq_enable;
  logic [31:0] next_rdata;
  logic [31:0] wr_bits;
  logic [31:0] cfg_wdata;
  logic [31:0] irq_set;
  logic [NUM_PINS-1:0] pin_match;
  logic wr_cfg;
  logic wr_status;
  logic wr_enable;
  logic route_write;
  glp_route_t route;

  //--------------------------------------------------------------------------
  // Bus slave. Every transfer completes with no wait state and an OKAY answer.
  //--------------------------------------------------------------------------

  assign HREADYOUT = 1'b1;
  assign HRESP = HRESP_OKAY;

  always_comb begin
    next_aphase = '0;
    if (HSEL && HREADY && (HTRANS == HTRANS_NONSEQ || HTRANS == 2'h3)) begin
      next_aphase.valid = 1'b1;
      next_aphase.write = HWRITE;
      // An address above the register page decodes to an unused offset here, so the data phase never looks at HADDR.
      next_aphase.addr = (HADDR[31:8] == 24'h00_0000) ? (HADDR[7:0] & ADDR_DECODE_MASK) : 8'h00;
      next_aphase.lanes = lane_mask(HSIZE, HADDR[1:0]);
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      aphase <= '0;
    end else begin
      aphase <= next_aphase;
    end
  end

  // Writes land in the data phase, when the write data is on the bus.
  assign wr_bits = lane_bits(aphase.lanes);
  assign wr_cfg = aphase.valid && aphase.write && (aphase.addr == ADDR_CFG[7:0]);
  assign wr_status = aphase.valid && aphase.write && (aphase.addr == ADDR_IRQ_STATUS[7:0]);
  assign wr_enable = aphase.valid && aphase.write && (aphase.addr == ADDR_IRQ_ENABLE[7:0]);

  //--------------------------------------------------------------------------
  // Configuration register.
  //--------------------------------------------------------------------------

  assign cfg_wdata = (cfg & ~(wr_bits & CFG_WMASK)) | (HWDATA & wr_bits & CFG_WMASK);

  always_comb begin
    next_cfg = cfg;
    if (wr_cfg) begin
      next_cfg = glp_cfg_t'(cfg_wdata);
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      cfg <= glp_cfg_t'(CFG_RESET);
    end else begin
      cfg <= next_cfg;
    end
  end

  assign route = glp_route_t'(cfg.serial_rom_pin_function);

  // A change of the ROM pin field is flagged when it is illegal or badly timed.
  assign route_write = wr_cfg && (next_cfg.serial_rom_pin_function != cfg.serial_rom_pin_function);

  //--------------------------------------------------------------------------
  // Pin interrupt qualification.
  //--------------------------------------------------------------------------

  generate
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_filter
      glp_level_filter u_filter (
        .clk(CLK),
        .resetn(RESETN),
        .level(GPIO_IN[i]),
        .active_high(cfg.pin_irq_level_select[i]),
        .armed(~cfg.indicator_select[i]),
        .match(pin_match[i])
      );
    end
  endgenerate

  //--------------------------------------------------------------------------
  // Interrupt status and enable.
  //--------------------------------------------------------------------------

  always_comb begin
    irq_set = 32'h0000_0000;
    irq_set[IRQ_PIN_LSB +: NUM_PINS] = pin_match;
    irq_set[IRQ_BAD_ROUTE] = route_write && !route_legal(next_cfg.serial_rom_pin_function);
    irq_set[IRQ_ROUTE_BUSY] = route_write && SROM_BUSY;
  end

  // A bit raised in the same cycle as its clear stays set.
  always_comb begin
    next_irq_status = irq_status;
    if (wr_status) begin
      next_irq_status = irq_status & ~(HWDATA & wr_bits & IRQ_WMASK);
    end
    next_irq_status = next_irq_status | irq_set;
  end

  always_comb begin
    next_irq_enable = irq_enable;
    if (wr_enable) begin
      next_irq_enable = (irq_enable & ~(wr_bits & IRQ_WMASK)) | (HWDATA & wr_bits & IRQ_WMASK);
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      irq_status <= IRQ_RESET;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      irq_enable <= IRQ_RESET;
    end else begin
      irq_enable <= next_irq_enable;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(next_irq_status & next_irq_enable);
    end
  end

  //--------------------------------------------------------------------------
  // Read path. Data is captured in the address phase from the next-state
  // values, so a read right behind a write sees the written value.
  //--------------------------------------------------------------------------

  always_comb begin
    glp_cfg_t view;
    view = glp_cfg_t'(32'(next_cfg) & CFG_WMASK);
    view.pin_value = GPIO_IN;
    next_rdata = 32'h0000_0000;
    if (next_aphase.valid && !next_aphase.write && (HADDR[31:8] == 24'h00_0000)) begin
      unique case (next_aphase.addr)
        ADDR_CFG[7:0]: next_rdata = view;
        ADDR_IRQ_STATUS[7:0]: next_rdata = next_irq_status & IRQ_WMASK;
        ADDR_IRQ_ENABLE[7:0]: next_rdata = next_irq_enable & IRQ_WMASK;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      HRDATA <= 32'h0000_0000;
    end else begin
      HRDATA <= next_rdata;
    end
  end

  //--------------------------------------------------------------------------
  // General pins. Drive values are registered so a pin never glitches while
  // the configuration and the indicator source settle.
  //--------------------------------------------------------------------------

  generate
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      glp_drive_t next_drive;

      always_comb begin
        if (cfg.indicator_select[i]) begin
          next_drive = pin_drive(LED_IND[i], cfg.pin_push_pull_select[i]);
        end else if (cfg.pin_direction[i]) begin
          next_drive = pin_drive(cfg.pin_value[i], cfg.pin_push_pull_select[i]);
        end else begin
          next_drive = '0;
        end
      end

      always_ff @(posedge CLK) begin
        if (!RESETN) begin
          GPIO_OUT[i] <= 1'b0;
          GPIO_OE[i] <= 1'b0;
        end else begin
          GPIO_OUT[i] <= next_drive.out;
          GPIO_OE[i] <= next_drive.oe;
        end
      end
    end
  endgenerate

  //--------------------------------------------------------------------------
  // Serial ROM pin routing. Borrowed MII and ROM signals pass straight
  // through; adding a flop would skew them against their own clocks.
  //--------------------------------------------------------------------------

  always_comb begin
    ROM_DATA_OUT = 1'b0;
    ROM_DATA_OE = 1'b0;
    SROM_DI = 1'b0;
    MII_TX_CLK = 1'b0;
    unique case (route)
      ROUTE_ROM: begin
        ROM_DATA_OUT = SROM_DO;
        ROM_DATA_OE = SROM_DOE;
        SROM_DI = ROM_DATA_IN;
      end
      ROUTE_GPO, ROUTE_GPO_RXDV: begin
        ROM_DATA_OUT = cfg.output_only_value[0];
        ROM_DATA_OE = 1'b1;
      end
      ROUTE_TXEN_GPO, ROUTE_TXEN_RXDV: begin
        ROM_DATA_OUT = MII_TX_EN;
        ROM_DATA_OE = 1'b1;
      end
      ROUTE_MII_CLK: begin
        MII_TX_CLK = ROM_DATA_IN;
      end
      ROUTE_RSV_A, ROUTE_RSV_B: begin
        ROM_DATA_OE = 1'b0;
      end
    endcase
  end

  always_comb begin
    ROM_CLK_OUT = 1'b0;
    ROM_CLK_OE = 1'b0;
    MII_RX_DV = 1'b0;
    MII_RX_CLK = 1'b0;
    unique case (route)
      ROUTE_ROM: begin
        ROM_CLK_OUT = SROM_CLK;
        ROM_CLK_OE = 1'b1;
      end
      ROUTE_GPO, ROUTE_TXEN_GPO: begin
        ROM_CLK_OUT = cfg.output_only_value[1];
        ROM_CLK_OE = 1'b1;
      end
      ROUTE_GPO_RXDV, ROUTE_TXEN_RXDV: begin
        MII_RX_DV = ROM_CLK_IN;
      end
      ROUTE_MII_CLK: begin
        MII_RX_CLK = ROM_CLK_IN;
      end
      ROUTE_RSV_A, ROUTE_RSV_B: begin
        ROM_CLK_OE = 1'b0;
      end
    endcase
  end

endmodule

`default_nettype wire

// ==== verification/glp_pin_config_properties.sv ====
// Port-level assertions for the pin function configuration block.
`default_nettype none

module glp_pin_config_properties (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic [glp_pkg::NUM_PINS-1:0] GPIO_OUT,
  input wire logic [glp_pkg::NUM_PINS-1:0] GPIO_OE,
  input wire logic ROM_DATA_OUT,
  input wire logic ROM_DATA_OE,
  input wire logic ROM_CLK_IN,
  input wire logic ROM_CLK_OUT,
  input wire logic ROM_CLK_OE,
  input wire logic SROM_CLK,
  input wire logic MII_TX_EN,
  input wire logic MII_RX_DV,
  input wire logic IRQ
);
  import glp_pkg::*;
  // The shadow only follows whole-word writes, which is all the bench issues.
  logic ap_wr;
  logic [7:0] ap_addr;
  glp_cfg_t sh;
  glp_cfg_t sh_d;
  logic [31:0] en;
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ap_wr <= 1'b0;
      ap_addr <= 8'h00;
    end else begin
      ap_wr <= HSEL && HREADY && HTRANS[1] && HWRITE;
      ap_addr <= HADDR[7:0];
    end
  end
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      sh <= CFG_RESET;
      en <= IRQ_RESET;
    end else if (ap_wr && ap_addr == ADDR_CFG[7:0]) begin
      sh <= HWDATA & CFG_WMASK;
    end else if (ap_wr && ap_addr == ADDR_IRQ_ENABLE[7:0]) begin
      en <= HWDATA & IRQ_WMASK;
    end
  end
  // Pin drivers are registered once more than the configuration itself.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      sh_d <= CFG_RESET;
    end else begin
      sh_d <= sh;
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  a_reset_quiet: assert property ($rose(RESETN) |-> GPIO_OE == 3'h0 && !IRQ && HRDATA == 32'h0000_0000)
    else $error("outputs not quiet after reset");
  a_rom_clock_route: assert property (sh.serial_rom_pin_function == ROUTE_ROM |-> ROM_CLK_OE && ROM_CLK_OUT == SROM_CLK)
    else $error("clock pin not given to the serial ROM");
  a_gpo_a_drive: assert property (sh.serial_rom_pin_function == ROUTE_GPO |->
    ROM_DATA_OE && ROM_DATA_OUT == sh.output_only_value[0])
    else $error("output-only value not on data pin");
  a_mii_borrow: assert property (sh.serial_rom_pin_function == ROUTE_TXEN_RXDV |->
    ROM_DATA_OUT == MII_TX_EN && MII_RX_DV == ROM_CLK_IN && !ROM_CLK_OE)
    else $error("MII signals not routed");
  a_push_pull_out: assert property (!sh_d.indicator_select[0] && sh_d.pin_direction[0] && sh_d.pin_push_pull_select[0]
    |-> GPIO_OE[0] && GPIO_OUT[0] == sh_d.pin_value[0])
    else $error("push-pull pin drive wrong");
  a_open_drain: assert property (!sh_d.indicator_select[1] && sh_d.pin_direction[1] && !sh_d.pin_push_pull_select[1]
    |-> GPIO_OE[1] == !sh_d.pin_value[1] && !(GPIO_OE[1] && GPIO_OUT[1]))
    else $error("open-drain pin drive wrong");
  a_input_float: assert property (!sh_d.indicator_select[2] && !sh_d.pin_direction[2] |-> !GPIO_OE[2])
    else $error("input pin is driven");
  a_indicator_drive: assert property (sh_d.indicator_select[0] && sh_d.pin_push_pull_select[0] |-> GPIO_OE[0])
    else $error("indicator pin not driven");
  a_irq_gated: assert property (IRQ |-> (en | $past(en)) != 32'h0000_0000)
    else $error("interrupt without any enable");
  c_mii_clk: cover property (sh.serial_rom_pin_function == ROUTE_MII_CLK);
  c_irq_rise: cover property ($rose(IRQ));
  c_open_drain: cover property (sh_d.pin_direction[1] && !sh_d.pin_push_pull_select[1]);
endmodule

`default_nettype wire

// ==== verification/tb_glp_pin_config.sv ====
// Self-checking bench for the pin function configuration block.
`default_nettype none

module tb_glp_pin_config;
  timeunit 1ns;
  timeprecision 1ns;
  import glp_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, gpio_in = 3'h6, led_ind = 3'h0, gpio_out, gpio_oe;
  logic rom_data_in = 1'b0, rom_clk_in = 1'b0, srom_do = 1'b0, srom_doe = 1'b1, srom_clk = 1'b0;
  logic srom_busy = 1'b0, mii_tx_en = 1'b0, hreadyout, hresp, rom_data_out, rom_data_oe, rom_clk_out, rom_clk_oe;
  logic srom_di, mii_tx_clk, mii_rx_dv, mii_rx_clk, irq;
  int n_fail = 0, num_checks = 0;
  glp_route_t routes [6] = '{ROUTE_ROM, ROUTE_GPO, ROUTE_GPO_RXDV, ROUTE_TXEN_GPO, ROUTE_TXEN_RXDV, ROUTE_MII_CLK};
  glp_pin_config glp_pin_config_i (.CLK(clk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .GPIO_IN(gpio_in), .GPIO_OUT(gpio_out), .GPIO_OE(gpio_oe), .LED_IND(led_ind),
    .ROM_DATA_IN(rom_data_in), .ROM_DATA_OUT(rom_data_out), .ROM_DATA_OE(rom_data_oe), .ROM_CLK_IN(rom_clk_in),
    .ROM_CLK_OUT(rom_clk_out), .ROM_CLK_OE(rom_clk_oe), .SROM_DO(srom_do), .SROM_DOE(srom_doe),
    .SROM_CLK(srom_clk), .SROM_BUSY(srom_busy), .SROM_DI(srom_di), .MII_TX_EN(mii_tx_en),
    .MII_TX_CLK(mii_tx_clk), .MII_RX_DV(mii_rx_dv), .MII_RX_CLK(mii_rx_clk), .IRQ(irq));
  always #10 clk = ~clk;
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Entered just after a rising edge; the address phase is held until hready is seen high.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    check(x, exp, what);
    check({31'h0000_0000, hresp}, {31'h0000_0000, HRESP_OKAY}, "okay response");
  endtask
  // Bits: data oe, data out, clock oe, clock out, rx_dv, tx_clk, rx_clk, rom data in.
  function automatic logic [7:0] route_exp(input glp_route_t r, input logic p);
    case (r)
      ROUTE_ROM: return {1'b1, p, 1'b1, ~p, 3'h0, ~p};
      ROUTE_GPO: return {1'b1, p, 1'b1, ~p, 4'h0};
      ROUTE_GPO_RXDV: return {1'b1, p, 2'h0, p, 3'h0};
      ROUTE_TXEN_GPO: return {1'b1, ~p, 1'b1, ~p, 4'h0};
      ROUTE_TXEN_RXDV: return {1'b1, ~p, 2'h0, p, 3'h0};
      default: return {5'h00, ~p, p, 1'b0};
    endcase
  endfunction
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    rd(ADDR_CFG, 32'h0000_0006, "config after reset");
    wr(ADDR_CFG, 32'hFFFF_FFFF);
    rd(ADDR_CFG, 32'h7777_071E, "reserved bits");
    wr(32'h0000_0090, 32'hFFFF_FFFF);
    rd(32'h0000_0090, 32'h0000_0000, "unmapped read");
    for (int p = 0; p < 2; p++) begin
      foreach (routes[i]) begin
        srom_do <= p[0];
        srom_clk <= ~p[0];
        mii_tx_en <= ~p[0];
        rom_data_in <= ~p[0];
        rom_clk_in <= p[0];
        wr(ADDR_CFG, {9'h000, routes[i], 15'h0000, ~p[0], p[0], 3'h0});
        repeat (2) @(posedge clk);
        check({24'h00_0000, rom_data_oe, rom_data_out & rom_data_oe, rom_clk_oe, rom_clk_out & rom_clk_oe,
          mii_rx_dv, mii_tx_clk, mii_rx_clk, srom_di}, {24'h00_0000, route_exp(routes[i], p[0])}, "route");
      end
    end
    wr(ADDR_CFG, 32'h0005_0706);
    repeat (3) @(posedge clk);
    check({26'h000_0000, gpio_oe, gpio_out & gpio_oe}, 32'h0000_002C, "drive modes");
    wr(ADDR_CFG, 32'h0005_0701);
    repeat (3) @(posedge clk);
    check({26'h000_0000, gpio_oe, gpio_out & gpio_oe}, 32'h0000_0039, "drive values");
    led_ind <= 3'h5;
    wr(ADDR_CFG, 32'h7007_0000);
    repeat (3) @(posedge clk);
    check({26'h000_0000, gpio_oe, gpio_out & gpio_oe}, 32'h0000_003D, "indicators");
    wr(ADDR_CFG, 32'h0100_0000);
    repeat (4) @(posedge clk);
    wr(ADDR_IRQ_STATUS, 32'h0000_001F);
    rd(ADDR_IRQ_STATUS, 32'h0000_0000, "no level match");
    wr(ADDR_IRQ_ENABLE, 32'h0000_0001);
    // One sample is shorter than the qualification time, so no event may be seen.
    gpio_in <= 3'h7;
    @(posedge clk);
    gpio_in <= 3'h6;
    repeat (4) @(posedge clk);
    rd(ADDR_IRQ_STATUS, 32'h0000_0000, "short pulse");
    gpio_in <= 3'h7;
    repeat (5) @(posedge clk);
    rd(ADDR_IRQ_STATUS, 32'h0000_0001, "high level event");
    check({31'h0000_0000, irq}, 32'h0000_0001, "irq enabled");
    gpio_in <= 3'h4;
    repeat (5) @(posedge clk);
    wr(ADDR_IRQ_STATUS, 32'h0000_0001);
    rd(ADDR_IRQ_STATUS, 32'h0000_0002, "low level event");
    repeat (2) @(posedge clk);
    check({31'h0000_0000, irq}, 32'h0000_0000, "irq masked");
    wr(ADDR_IRQ_ENABLE, 32'h0000_0002);
    repeat (3) @(posedge clk);
    check({31'h0000_0000, irq}, 32'h0000_0001, "irq unmasked");
    wr(ADDR_IRQ_ENABLE, 32'h0000_0000);
    repeat (3) @(posedge clk);
    check({31'h0000_0000, irq}, 32'h0000_0000, "irq off");
    // A reset in mid-run must clear a fully programmed register, not just keep an idle one at zero.
    wr(ADDR_CFG, 32'h7777_071F);
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    check({26'h000_0000, gpio_oe, gpio_out}, 32'h0000_0000, "pins during reset");
    resetn <= 1'b1;
    @(posedge clk);
    rd(ADDR_CFG, 32'h0000_0004, "config after second reset");
    rd(ADDR_IRQ_ENABLE, 32'h0000_0000, "enable after second reset");
    summarize();
  end
endmodule

bind glp_pin_config glp_pin_config_properties glp_pin_config_properties_i (.CLK(CLK), .RESETN(RESETN),
  .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
  .HRDATA(HRDATA), .GPIO_OUT(GPIO_OUT), .GPIO_OE(GPIO_OE), .ROM_DATA_OUT(ROM_DATA_OUT),
  .ROM_DATA_OE(ROM_DATA_OE), .ROM_CLK_IN(ROM_CLK_IN), .ROM_CLK_OUT(ROM_CLK_OUT), .ROM_CLK_OE(ROM_CLK_OE),
  .SROM_CLK(SROM_CLK), .MII_TX_EN(MII_TX_EN), .MII_RX_DV(MII_RX_DV), .IRQ(IRQ));

`default_nettype wire
